//--- hdl/alu_consts.svh
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH
// Instruction word fields.
`define ALU_OPC_HI 15
`define ALU_OPC_LO 12
`define ALU_DST_HI 11
`define ALU_DST_LO 8
`define ALU_SRC_HI 7
`define ALU_SRC_LO 4
`define ALU_SUB_HI 3
`define ALU_SUB_LO 0
`define ALU_IMM_HI 7
`define ALU_IMM_LO 0
// Top nibble that selects the register-register form.
`define ALU_REG_FORM 4'hc
// Highest operation code handled here.
`define ALU_OP_MAX 4'h7
// Operand and register file sizes.
`define ALU_WIDTH 8
`define ALU_NREG 16
`define ALU_ZERO_BYTE 8'h00
`define ALU_ZERO_WORD 16'h0000
`endif

//--- hdl/alu_pkg.sv
package alu_pkg;
    // Operation selector, in encoding order of the low opcode nibble.
    typedef enum logic [2:0] {
        ALU_OP_LOAD,
        ALU_OP_AND,
        ALU_OP_OR,
        ALU_OP_XOR,
        ALU_OP_ADD,
        ALU_OP_ADDC,
        ALU_OP_SUB,
        ALU_OP_SUBB
    } alu_op_t;
    typedef logic [7:0] alu_byte_t;
endpackage

//--- hdl/alu_regfile.sv
`timescale 1ns/10ps
`include "alu_consts.svh"
// Sixteen general registers, two read ports, one write port.
module alu_regfile
    import alu_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Read ports.
    input wire logic [3:0] rd_a_addr,
    input wire logic [3:0] rd_b_addr,
    output alu_pkg::alu_byte_t rd_a_data,
    output alu_pkg::alu_byte_t rd_b_data,
    // Write port.
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input wire alu_pkg::alu_byte_t wr_data
);
    alu_byte_t regs_ff [`ALU_NREG];

    // Registers clear on reset so that simulation starts defined.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < `ALU_NREG; i++) begin
                regs_ff[i] <= `ALU_ZERO_BYTE;
            end
        end else if (wr_en) begin
            regs_ff[wr_addr] <= wr_data;
        end
    end

    assign rd_a_data = regs_ff[rd_a_addr];
    assign rd_b_data = regs_ff[rd_b_addr];
endmodule

//--- hdl/alu_core.sv
`timescale 1ns/10ps
`include "alu_consts.svh"
// Purely combinational 8-bit operation unit.
module alu_core
    import alu_pkg::*;
(
    // Operation and operands.
    input wire alu_pkg::alu_op_t op,
    input wire alu_pkg::alu_byte_t opa,
    input wire alu_pkg::alu_byte_t opb,
    input wire logic carry_in,
    // Result.
    output alu_pkg::alu_byte_t result,
    output logic carry_out,
    output logic flags_upd
);
    logic [`ALU_WIDTH:0] wide;

    // Nine-bit arithmetic; the top bit is carry on add and borrow on subtract.
    always_comb begin
        wide = {1'b0, `ALU_ZERO_BYTE};
        flags_upd = 1'b1;
        case (op)
            ALU_OP_LOAD: begin
                wide = {1'b0, opb};
                flags_upd = 1'b0;
            end
            ALU_OP_AND: wide = {1'b0, opa & opb};
            ALU_OP_OR: wide = {1'b0, opa | opb};
            ALU_OP_XOR: wide = {1'b0, opa ^ opb};
            ALU_OP_ADD: wide = {1'b0, opa} + {1'b0, opb};
            ALU_OP_ADDC: wide = {1'b0, opa} + {1'b0, opb}
                + {8'h00, carry_in};
            ALU_OP_SUB: wide = {1'b0, opa} - {1'b0, opb};
            ALU_OP_SUBB: wide = {1'b0, opa} - {1'b0, opb}
                - {8'h00, carry_in};
            default: wide = {1'b0, opb};
        endcase
        result = wide[`ALU_WIDTH-1:0];
        carry_out = wide[`ALU_WIDTH];
    end
endmodule

//--- hdl/alu_top.sv
`timescale 1ns/10ps
`include "alu_consts.svh"
// Functional notes
// - Load copies operand, flags untouched.
// - Every operation takes two clock cycles.
// - Cxy0 loads register, 0xkk loads constant.
// - And: Cxy1 register, 1xkk immediate.
// - Or: Cxy2 register, 2xkk immediate.
// - Xor: Cxy3 register, 3xkk immediate.
// - Or with zero clears carry, tests zero.
// - Zero flag reflects an all-zero result.
// - Add ignores carry in: Cxy4/4xkk.
// - Add with carry includes carry flag.
// - Subtract ignores carry in: Cxy6/6xkk.
// - Subtract sets carry on underflow.
// - Subtract with borrow uses carry as borrow.
// - First register is source and destination.
// - Immediate is the low instruction byte.
// - Full byte constants, sixteen registers each.
module alu_top
    import alu_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Instruction issue from the decoder.
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    // Issue handshake and completion.
    output logic busy_ff,
    output logic done_ff,
    output logic illegal_ff,
    // Flags for conditional branching.
    output logic zero_flag_ff,
    output logic carry_flag_ff,
    // Last result written back.
    output alu_pkg::alu_byte_t result_ff,
    output logic [3:0] result_reg_ff
);
    import alu_pkg::*;

    // ========================================================================
    // Instruction capture and decode
    // ========================================================================
    typedef enum logic [0:0] {
        ALU_ST_IDLE,
        ALU_ST_EXEC
    } alu_state_t;

    alu_state_t state_ff;
    alu_state_t nxt_state;
    logic [15:0] instr_ff;
    logic [3:0] opc_hi;
    logic [3:0] dst_sel;
    logic [3:0] src_sel;
    logic [3:0] sub_op;
    logic reg_form;
    logic legal;
    alu_op_t op;
    alu_byte_t imm;
    alu_byte_t opa;
    alu_byte_t opb_reg;
    alu_byte_t opb;
    alu_byte_t res;
    logic cout;
    logic upd;
    logic accept;
    logic commit;

    assign accept = (state_ff == ALU_ST_IDLE) && instr_valid;
    assign commit = (state_ff == ALU_ST_EXEC);

    // Capture the word at issue so the decoder may move on meanwhile.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            instr_ff <= `ALU_ZERO_WORD;
        end else if (accept) begin
            instr_ff <= instr;
        end
    end

    // Field split; register form uses the low nibble as operation.
    assign opc_hi = instr_ff[`ALU_OPC_HI:`ALU_OPC_LO];
    assign dst_sel = instr_ff[`ALU_DST_HI:`ALU_DST_LO];
    assign src_sel = instr_ff[`ALU_SRC_HI:`ALU_SRC_LO];
    assign sub_op = instr_ff[`ALU_SUB_HI:`ALU_SUB_LO];
    assign imm = instr_ff[`ALU_IMM_HI:`ALU_IMM_LO];
    assign reg_form = (opc_hi == `ALU_REG_FORM);

    // Opcode nibble maps straight onto the operation encoding.
    // Codes above seven belong to other units; they are flagged, not executed.
    always_comb begin
        op = ALU_OP_LOAD;
        legal = 1'b0;
        if (reg_form) begin
            legal = (sub_op <= `ALU_OP_MAX);
            op = alu_op_t'(sub_op[2:0]);
        end else begin
            legal = (opc_hi <= `ALU_OP_MAX);
            op = alu_op_t'(opc_hi[2:0]);
        end
    end

    // ========================================================================
    // Register file and operation unit
    // ========================================================================
    alu_regfile alu_regfile_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .rd_a_addr(dst_sel),
        .rd_b_addr(src_sel),
        .rd_a_data(opa),
        .rd_b_data(opb_reg),
        .wr_en(commit && legal),
        .wr_addr(dst_sel),
        .wr_data(res)
    );

    // Second operand is the register or the embedded constant.
    assign opb = reg_form ? opb_reg : imm;

    alu_core alu_core_inst (
        .op(op),
        .opa(opa),
        .opb(opb),
        .carry_in(carry_flag_ff),
        .result(res),
        .carry_out(cout),
        .flags_upd(upd)
    );

    // ========================================================================
    // Two-cycle sequencing
    // ========================================================================
    // Issue cycle captures, execute cycle commits; no overlap, which keeps
    // operand reads clear of any write hazard at the cost of throughput.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ALU_ST_IDLE: if (instr_valid) nxt_state = ALU_ST_EXEC;
            ALU_ST_EXEC: nxt_state = ALU_ST_IDLE;
            default: nxt_state = ALU_ST_IDLE;
        endcase
    end

    // State register for the issue and execute phases.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= ALU_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Busy is high for the execute cycle; issue only while low.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= accept;
        end
    end

    // Done pulses once, in the cycle after commit.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            done_ff <= 1'b0;
            illegal_ff <= 1'b0;
        end else begin
            done_ff <= commit;
            illegal_ff <= commit && !legal;
        end
    end

    // ========================================================================
    // Flags and result, committed with the register write
    // ========================================================================
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            zero_flag_ff <= 1'b0;
            carry_flag_ff <= 1'b0;
        end else if (commit && legal && upd) begin
            zero_flag_ff <= (res == `ALU_ZERO_BYTE);
            carry_flag_ff <= cout;
        end
    end

    // Result copy moves with the register write, so both read the same value.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            result_ff <= `ALU_ZERO_BYTE;
            result_reg_ff <= 4'h0;
        end else if (commit && legal) begin
            result_ff <= res;
            result_reg_ff <= dst_sel;
        end
    end

    // ========================================================================
    // Checks
    // ========================================================================
    // Each result and flag check looks one edge after commit, where result and flags settle.
    // Expected values, except the zero flag compared against result_ff, are rebuilt from the sampled operands, not from res.
    chk_two_cycle: assert property (@(posedge sys_clk) disable iff (rst)
        accept |=> busy_ff ##1 (done_ff && !busy_ff))
        else $error("Instruction did not finish in two cycles");

    chk_load_flags: assert property (@(posedge sys_clk) disable iff (rst)
        (commit && legal && op == ALU_OP_LOAD) |=>
        $stable(zero_flag_ff) && $stable(carry_flag_ff))
        else $error("Load changed a flag");

    chk_load_value: assert property (@(posedge sys_clk) disable iff (rst)
        (commit && legal && op == ALU_OP_LOAD) |=> result_ff == $past(opb))
        else $error("Load wrote the wrong value");

    chk_zero_flag: assert property (@(posedge sys_clk) disable iff (rst)
        (done_ff && !illegal_ff && $past(op) != ALU_OP_LOAD) |->
        zero_flag_ff == (result_ff == `ALU_ZERO_BYTE))
        else $error("Zero flag disagrees with result");

    chk_logic_carry: assert property (@(posedge sys_clk) disable iff (rst)
        (commit && legal && (op == ALU_OP_AND || op == ALU_OP_OR || op == ALU_OP_XOR))
        |=> !carry_flag_ff)
        else $error("Logic operation left carry set");

    chk_sub_borrow: assert property (@(posedge sys_clk) disable iff (rst)
        (commit && legal && op == ALU_OP_SUB) |=>
        carry_flag_ff == ($past(opa) < $past(opb)))
        else $error("Subtract borrow wrong");

    chk_add_carry: assert property (@(posedge sys_clk) disable iff (rst)
        (commit && legal && op == ALU_OP_ADD) |=>
        {carry_flag_ff, result_ff} == {1'b0, $past(opa)} + {1'b0, $past(opb)})
        else $error("Add sum or carry wrong");

    chk_addc_sum: assert property (@(posedge sys_clk) disable iff (rst)
        (commit && legal && op == ALU_OP_ADDC) |=>
        {carry_flag_ff, result_ff} ==
        {1'b0, $past(opa)} + {1'b0, $past(opb)} + {8'h00, $past(carry_flag_ff)})
        else $error("Add with carry wrong");

    chk_subb_diff: assert property (@(posedge sys_clk) disable iff (rst)
        (commit && legal && op == ALU_OP_SUBB) |=>
        {carry_flag_ff, result_ff} ==
        {1'b0, $past(opa)} - {1'b0, $past(opb)} - {8'h00, $past(carry_flag_ff)})
        else $error("Subtract with borrow wrong");

    chk_sub_diff: assert property (@(posedge sys_clk) disable iff (rst)
        (commit && legal && op == ALU_OP_SUB) |=>
        result_ff == $past(opa) - $past(opb))
        else $error("Subtract difference wrong");

    // Bitwise results, one check for each logic operation.
    chk_and_value: assert property (@(posedge sys_clk) disable iff (rst)
        (commit && legal && op == ALU_OP_AND) |=>
        result_ff == ($past(opa) & $past(opb)))
        else $error("And result wrong");

    chk_or_value: assert property (@(posedge sys_clk) disable iff (rst)
        (commit && legal && op == ALU_OP_OR) |=>
        result_ff == ($past(opa) | $past(opb)))
        else $error("Or result wrong");

    chk_xor_value: assert property (@(posedge sys_clk) disable iff (rst)
        (commit && legal && op == ALU_OP_XOR) |=>
        result_ff == ($past(opa) ^ $past(opb)))
        else $error("Xor result wrong");

    // Or with a zero constant is the idiom for testing a register.
    chk_or_zero: assert property (@(posedge sys_clk) disable iff (rst)
        (commit && legal && op == ALU_OP_OR && !reg_form && imm == `ALU_ZERO_BYTE) |=>
        result_ff == $past(opa) && !carry_flag_ff &&
        zero_flag_ff == ($past(opa) == `ALU_ZERO_BYTE))
        else $error("Or with zero altered register or flags");

    chk_dest_index: assert property (@(posedge sys_clk) disable iff (rst)
        (commit && legal) |=> result_reg_ff == $past(dst_sel))
        else $error("Result reported for the wrong register");

    // A foreign opcode must leave the result, the result register index and both flags alone.
    chk_illegal_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        (commit && !legal) |=> $stable(result_ff) && $stable(result_reg_ff) &&
        $stable(zero_flag_ff) && $stable(carry_flag_ff))
        else $error("Illegal opcode changed result or flags");

    chk_done_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        done_ff |=> !done_ff)
        else $error("Done stood longer than one cycle");

    chk_busy_once: assert property (@(posedge sys_clk) disable iff (rst)
        busy_ff |=> !busy_ff)
        else $error("Busy stood longer than one cycle");

    cov_add_overflow: cover property (@(posedge sys_clk) disable iff (rst)
        commit && op == ALU_OP_ADD && cout);
    cov_sub_underflow: cover property (@(posedge sys_clk) disable iff (rst)
        commit && op == ALU_OP_SUB && cout);
    cov_reg_form: cover property (@(posedge sys_clk) disable iff (rst)
        commit && reg_form && op == ALU_OP_XOR);
    // A new word taken in the very cycle that reports the last one.
    cov_back_to_back: cover property (@(posedge sys_clk) disable iff (rst)
        done_ff && accept);
    cov_subb_borrow: cover property (@(posedge sys_clk) disable iff (rst)
        commit && op == ALU_OP_SUBB && cout);
endmodule

//--- dv/alu_top_test.sv
`timescale 1ns/10ps
// ==================================================
// Self-checking bench for the ALU datapath
module alu_top_test;
    import alu_pkg::*;
    logic sys_clk;
    logic rst;
    logic instr_valid;
    logic [15:0] instr;
    logic busy_ff, done_ff, illegal_ff, zero_flag_ff, carry_flag_ff;
    alu_byte_t result_ff;
    logic [3:0] result_reg_ff;
    alu_byte_t mr [16];
    logic mz, mc;
    alu_byte_t er;
    logic [3:0] ed;
    int bad_count, n_tests, cyc;

    alu_top alu_top_inst (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid),
        .instr(instr), .busy_ff(busy_ff), .done_ff(done_ff), .illegal_ff(illegal_ff),
        .zero_flag_ff(zero_flag_ff), .carry_flag_ff(carry_flag_ff),
        .result_ff(result_ff), .result_reg_ff(result_reg_ff));

    // ==================================================
    // Clock and a cycle ceiling, so a hung handshake still ends the run.
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            close_out();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ==================================================
    // Reference model: first register is source and destination.
    task automatic predict(input logic [15:0] w);
        logic [3:0] op;
        alu_byte_t a, b;
        logic [8:0] s;
        op = (w[15:12] == 4'hc) ? w[3:0] : w[15:12];
        ed = w[11:8];
        a = mr[ed];
        b = (w[15:12] == 4'hc) ? mr[w[7:4]] : w[7:0];
        case (op)
            4'h0: s = {1'b0, b};
            4'h1: s = {1'b0, a & b};
            4'h2: s = {1'b0, a | b};
            4'h3: s = {1'b0, a ^ b};
            4'h4: s = {1'b0, a} + {1'b0, b};
            4'h5: s = {1'b0, a} + {1'b0, b} + {8'h00, mc};
            4'h6: s = {1'b0, a} - {1'b0, b};
            default: s = {1'b0, a} - {1'b0, b} - {8'h00, mc};
        endcase
        if (op != 4'h0) begin
            mz = (s[7:0] == 8'h00);
            mc = s[8];
        end
        mr[ed] = s[7:0];
        er = s[7:0];
    endtask

    task automatic verify();
        check("result", {8'h00, result_ff}, {8'h00, er});
        check("dest", {12'h000, result_reg_ff}, {12'h000, ed});
        check("zero", {15'h0, zero_flag_ff}, {15'h0, mz});
        check("carry", {15'h0, carry_flag_ff}, {15'h0, mc});
    endtask

    // One instruction: taken at the next edge, done exactly one edge later.
    task automatic issue(input logic [15:0] w, input logic il);
        @(posedge sys_clk);
        instr_valid <= 1'b1;
        instr <= w;
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        #1 check("busy", {15'h0, busy_ff}, 16'h1);
        check("early_done", {15'h0, done_ff}, 16'h0);
        @(posedge sys_clk);
        #1 check("done", {15'h0, done_ff}, 16'h1);
        check("illegal", {15'h0, illegal_ff}, {15'h0, il});
    endtask

    task automatic run(input logic [15:0] w);
        predict(w);
        issue(w, 1'b0);
        verify();
    endtask

    // ==================================================
    // Scenarios.
    task automatic t_load();
        run(16'h4aff);
        run(16'h4a01);
        for (int i = 0; i < 16; i++) begin
            run({4'h0, i[3:0], 8'h11 * i[7:0]});
        end
        run(16'hc3f0);
        check("load_reg", {8'h00, result_ff}, 16'h00ff);
        run(16'hc000);
        $display("Test load done");
    endtask

    task automatic t_logic();
        run(16'h0233);
        for (int k = 1; k < 4; k++) begin
            run(16'h010f);
            run({k[3:0], 4'h1, 8'h33});
            run(16'h010f);
            run({8'hc1, 4'h2, k[3:0]});
        end
        run(16'h0100);
        run(16'h0eff);
        run(16'h4e01);
        run(16'h2100);
        run(16'h0181);
        run(16'h2100);
        $display("Test logic done");
    endtask

    task automatic t_arith();
        run(16'h0b10);
        run(16'h4b05);
        check("add", {8'h00, result_ff}, 16'h0015);
        run(16'h0aff);
        run(16'h4a01);
        run(16'h5b00);
        check("addc", {8'h00, result_ff}, 16'h0016);
        run(16'hcab4);
        run(16'hcab5);
        run(16'h0527);
        run(16'h6535);
        check("sub", {8'h00, result_ff}, 16'h00f2);
        run(16'h7500);
        check("subb", {8'h00, result_ff}, 16'h00f1);
        run(16'h65f1);
        run(16'hc5b6);
        run(16'hc5b7);
        run(16'h75ff);
        run(16'h7500);
        check("subb_chain", {8'h00, result_ff}, 16'h00d3);
        $display("Test arith done");
    endtask

    // Request held high: the second word is refused while busy.
    task automatic t_b2b();
        @(posedge sys_clk);
        instr_valid <= 1'b1;
        instr <= 16'h0180;
        predict(16'h0180);
        @(posedge sys_clk);
        instr <= 16'hc214;
        @(posedge sys_clk);
        #1 verify();
        predict(16'hc214);
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        #1 check("busy2", {15'h0, busy_ff}, 16'h1);
        @(posedge sys_clk);
        #1 check("done2", {15'h0, done_ff}, 16'h1);
        verify();
        $display("Test back_to_back done");
    endtask

    task automatic t_illegal();
        issue(16'h8123, 1'b1);
        verify();
        issue(16'hc128, 1'b1);
        verify();
        run(16'hc110);
        $display("Test illegal done");
    endtask

    // Mid-run reset: outputs, flags and registers all return to zero.
    task automatic t_reset();
        run(16'h4f01);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        #1 check("rst_ctrl", {13'h0, busy_ff, done_ff, illegal_ff}, 16'h0);
        check("rst_flags", {14'h0, zero_flag_ff, carry_flag_ff}, 16'h0);
        check("rst_result", {4'h0, result_reg_ff, result_ff}, 16'h0);
        mz = 1'b0;
        mc = 1'b0;
        for (int i = 0; i < 16; i++) begin
            mr[i] = 8'h00;
        end
        run(16'hc7d4);
        $display("Test reset done");
    endtask

    initial begin
        rst = 1'b1;
        instr_valid = 1'b0;
        instr = 16'h0000;
        bad_count = 0;
        n_tests = 0;
        mz = 1'b0;
        mc = 1'b0;
        for (int i = 0; i < 16; i++) begin
            mr[i] = 8'h00;
        end
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        run(16'h2500);
        t_load();
        t_logic();
        t_arith();
        t_b2b();
        t_illegal();
        t_reset();
        close_out();
    end
endmodule
